/* File: inc/opseq_pkg.sv */
// shared constants and types for the operand bus access sequencer
package opseq_pkg;

   // transfer and operand sizes, coded as a count of bytes
   localparam logic [2:0] XFER_PROBE = 3'h0;
   localparam logic [2:0] XFER_BYTE  = 3'h1;
   localparam logic [2:0] XFER_HALF  = 3'h2;
   localparam logic [2:0] XFER_THREE = 3'h3;
   localparam logic [2:0] XFER_WORD  = 3'h4;

   // bytes a port carries from an aligned offset
   localparam logic [2:0] PORT32_BYTES = 3'h4;
   localparam logic [2:0] PORT16_BYTES = 3'h2;

   // lane and width figures
   localparam int unsigned BYTE_BITS = 8;
   localparam int unsigned LANES     = 4;

   // reset values, and the offset of the first byte of a word
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [2:0]  CNT_RST  = 3'h0;
   localparam logic [1:0]  OFF_WORD = 2'h0;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ISSUE  = 2'b01,
      ST_WAIT   = 2'b10,
      ST_FINISH = 2'b11
   } seq_state_t;

   // order of the pieces of one operand
   typedef enum logic [1:0] {
      PH_PROBE = 2'b00,
      PH_NEXT  = 2'b01,
      PH_ORIG  = 2'b10,
      PH_ONLY  = 2'b11
   } seq_phase_t;

endpackage : opseq_pkg

/* File: logic/operand_extend.sv */
// widens a fetched byte or halfword operand to a full 32-bit value
`timescale 1ns/100ps
module operand_extend (
   input  wire logic [31:0] raw,
   input  wire logic [2:0]  opnd_size,
   input  wire logic        sgn,
   output logic      [31:0] value
);

   always_comb begin
      case (opnd_size)
         opseq_pkg::XFER_BYTE: begin
            if (sgn) begin
               value = {{24{raw[7]}}, raw[7:0]};
            end else begin
               value = {24'h00_0000, raw[7:0]};
            end
         end
         opseq_pkg::XFER_HALF: begin
            if (sgn) begin
               value = {{16{raw[15]}}, raw[15:0]};
            end else begin
               value = {16'h0000, raw[15:0]};
            end
         end
         default: begin
            value = raw;
         end
      endcase
   end

endmodule : operand_extend

/* File: logic/write_lanes.sv */
// places operand bytes on the four write lanes, with replication
`timescale 1ns/100ps
module write_lanes (
   input  wire logic [31:0] data,
   input  wire logic [2:0]  opnd_size,
   input  wire logic [2:0]  pos,
   input  wire logic [2:0]  cnt,
   input  wire logic [1:0]  off,
   output logic      [31:0] lanes
);

   // operand byte i counted from the most significant byte;
   // bits above the operand size are never picked
   function automatic logic [7:0] opnd_byte(input logic [31:0] d,
                                             input logic [2:0]  sz,
                                             input logic [2:0]  i);
      logic [31:0] sh;
      sh = d >> (8 * (32'(sz) - 32'(i) - 32'd1));
      return sh[7:0];
   endfunction : opnd_byte

   // byte driven on lane j when the lane is active
   function automatic logic [7:0] active_byte(input logic [1:0] j);
      return opnd_byte(data, opnd_size, 3'(pos + {1'b0, j} - {1'b0, off}));
   endfunction : active_byte

   genvar j;
   generate
      for (j = 0; j < opseq_pkg::LANES; j++) begin : g_lane
         localparam logic [1:0] LJ = 2'(j);
         logic in_range;
         assign in_range = ({1'b0, LJ} >= {1'b0, off}) &&
                           ({1'b0, LJ} < 3'({1'b0, off} + cnt));
         always_comb begin
            if (cnt == opseq_pkg::XFER_BYTE) begin
               lanes[31-8*j -: 8] = active_byte(off);
            end else if (cnt == opseq_pkg::XFER_HALF && !off[0]) begin
               // mirror onto the other halfword so a 16-bit port sees it
               lanes[31-8*j -: 8] = active_byte({off[1], LJ[0]});
            end else if (in_range) begin
               lanes[31-8*j -: 8] = active_byte(LJ);
            end else begin
               // undefined lanes: driven low
               lanes[31-8*j -: 8] = 8'h00;
            end
         end
      end
   endgenerate

endmodule : write_lanes

/* File: logic/operand_bus_access_sequencer.sv */
// sequences operand reads and writes into bus transactions
`timescale 1ns/100ps
module operand_bus_access_sequencer (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   // operand request side
   input  wire logic        op_req,
   input  wire logic        op_write,
   input  wire logic        op_signed,
   input  wire logic [2:0]  op_size,
   input  wire logic [31:0] op_addr,
   input  wire logic [31:0] op_wdata,
   input  wire logic        unaligned_enable,
   input  wire logic        virtual_mode,
   output logic             op_busy,
   output logic             op_done,
   output logic             op_fault,
   output logic      [31:0] op_rdata,
   // external bus side
   output logic             bus_req,
   output logic      [31:0] bus_addr,
   output logic      [2:0]  transfer_size,
   output logic             bus_write,
   output logic      [31:0] bus_wdata,
   input  wire logic        bus_ack,
   input  wire logic        bus_port16,
   input  wire logic [31:0] bus_rdata
);

   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      opseq_pkg::seq_state_t st;
      opseq_pkg::seq_phase_t ph;
      logic                  write;
      logic                  sgn;
      logic [2:0]            osize;
      logic [31:0]           oaddr;
      logic [31:0]           wdata;
      logic [31:0]           addr;
      logic [2:0]            rem;
      logic [2:0]            pos;
      logic                  port16;
      logic [31:0]           acc;
      logic                  busy;
      logic                  done;
      logic                  fault;
      logic [31:0]           rdata;
      logic                  req;
      logic [31:0]           baddr;
      logic [2:0]            bsize;
      logic                  bwrite;
      logic [31:0]           bwdata;
   } seq_regs_t;

   seq_regs_t s_r;
   seq_regs_t s_nxt;

   logic [31:0] lanes;
   logic [31:0] ext_value;
   logic [2:0]  issue_cnt;
   logic [2:0]  taken_cnt;
   logic        misaligned;
   logic        crossing;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // bytes one transaction moves: bounded by what remains and by the
   // end of the word (32-bit port) or halfword (16-bit port)
   function automatic logic [2:0] xfer_count(input logic [2:0] rem,
                                              input logic [1:0] off,
                                              input logic       p16);
      logic [2:0] lim;
      if (p16) begin
         lim = 3'(opseq_pkg::PORT16_BYTES - {2'b00, off[0]});
      end else begin
         lim = 3'(opseq_pkg::PORT32_BYTES - {1'b0, off});
      end
      return (rem < lim) ? rem : lim;
   endfunction : xfer_count

   // read lane of the i-th byte of a transaction at offset off
   function automatic logic [7:0] read_byte(input logic [31:0] d,
                                             input logic [1:0]  off,
                                             input logic        p16,
                                             input logic [2:0]  i);
      logic [2:0]  lane;
      logic [31:0] sh;
      // a 16-bit port answers on the upper half only
      lane = p16 ? 3'({2'b00, off[0]} + i) : 3'({1'b0, off} + i);
      sh   = d >> (8 * (32'd3 - 32'(lane)));
      return sh[7:0];
   endfunction : read_byte

   // the first piece of an operand is always sized for a 32-bit port;
   // a narrow acknowledge only shrinks what that piece really moved
   assign issue_cnt  = xfer_count(s_r.rem, s_r.addr[1:0], s_r.port16);
   assign taken_cnt  = xfer_count(s_r.bsize, s_r.addr[1:0], s_r.port16 | bus_port16);
   // only halfwords and words have an alignment boundary
   assign misaligned = ((op_size == opseq_pkg::XFER_HALF) && op_addr[0]) ||
                       ((op_size == opseq_pkg::XFER_WORD) && (op_addr[1:0] != 2'h0));
   // the operand runs past the last byte of its word
   assign crossing   = (4'({2'b00, op_addr[1:0]}) + {1'b0, op_size}) > 4'h4;

   write_lanes u_lanes (
      .data      (s_r.wdata),
      .opnd_size (s_r.osize),
      .pos       (s_r.pos),
      .cnt       (issue_cnt),
      .off       (s_r.addr[1:0]),
      .lanes     (lanes)
   );

   operand_extend u_extend (
      .raw       (s_r.acc),
      .opnd_size (s_r.osize),
      .sgn       (s_r.sgn),
      .value     (ext_value)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing

   always_comb begin
      s_nxt      = s_r;
      s_nxt.done  = 1'b0;
      s_nxt.fault = 1'b0;
      case (s_r.st)
         opseq_pkg::ST_IDLE: begin
            if (op_req) begin
               s_nxt.write  = op_write;
               s_nxt.sgn    = op_signed;
               s_nxt.osize  = op_size;
               s_nxt.oaddr  = op_addr;
               s_nxt.wdata  = op_wdata;
               s_nxt.addr   = op_addr;
               s_nxt.rem    = op_size;
               s_nxt.pos    = opseq_pkg::CNT_RST;
               s_nxt.port16 = 1'b0;
               s_nxt.acc    = opseq_pkg::WORD_RST;
               if (misaligned && !unaligned_enable) begin
                  // no bus cycle at all: the fault is reported instead
                  s_nxt.fault = 1'b1;
                  s_nxt.done  = 1'b1;
               end else begin
                  s_nxt.busy = 1'b1;
                  s_nxt.st   = opseq_pkg::ST_ISSUE;
                  if (op_write && virtual_mode && crossing) begin
                     // probe first so a fault on either word leaves memory untouched
                     s_nxt.ph = opseq_pkg::PH_PROBE;
                  end else begin
                     s_nxt.ph = opseq_pkg::PH_ONLY;
                  end
               end
            end
         end
         opseq_pkg::ST_ISSUE: begin
            s_nxt.req    = 1'b1;
            s_nxt.bwrite = s_r.write;
            s_nxt.baddr  = s_r.addr;
            if (s_r.ph == opseq_pkg::PH_PROBE) begin
               // a probe carries no data, so its lanes stay low
               s_nxt.bsize  = opseq_pkg::XFER_PROBE;
               s_nxt.bwdata = opseq_pkg::WORD_RST;
            end else begin
               s_nxt.bsize  = issue_cnt;
               s_nxt.bwdata = s_r.write ? lanes : opseq_pkg::WORD_RST;
            end
            s_nxt.st = opseq_pkg::ST_WAIT;
         end
         opseq_pkg::ST_WAIT: begin
            if (bus_ack) begin
               s_nxt.req    = 1'b0;
               s_nxt.port16 = s_r.port16 | bus_port16;
               s_nxt.st     = opseq_pkg::ST_ISSUE;
               if (s_r.ph == opseq_pkg::PH_PROBE) begin
                  // part lying in the next word goes out first
                  s_nxt.ph   = opseq_pkg::PH_NEXT;
                  s_nxt.addr = {s_r.oaddr[31:2] + 30'h1, opseq_pkg::OFF_WORD};
                  s_nxt.pos  = 3'(opseq_pkg::PORT32_BYTES - {1'b0, s_r.oaddr[1:0]});
                  s_nxt.rem  = 3'({1'b0, s_r.oaddr[1:0]} + s_r.osize
                                  - opseq_pkg::PORT32_BYTES);
               end else begin
                  if (!s_r.write) begin
                     // bytes arrive in address order, most significant first
                     for (int i = 0; i < opseq_pkg::LANES; i++) begin
                        if (3'(i) < taken_cnt) begin
                           s_nxt.acc = {s_nxt.acc[23:0],
                                        read_byte(bus_rdata, s_r.addr[1:0],
                                                  s_r.port16 | bus_port16, 3'(i))};
                        end
                     end
                  end
                  // a 16-bit port may take fewer bytes than were offered; the
                  // leftover goes out again from the first byte it did not take
                  s_nxt.addr = s_r.addr + {29'h0000_0000, taken_cnt};
                  s_nxt.pos  = 3'(s_r.pos + taken_cnt);
                  s_nxt.rem  = 3'(s_r.rem - taken_cnt);
                  if (s_r.rem == taken_cnt) begin
                     if (s_r.ph == opseq_pkg::PH_NEXT) begin
                        // then the part in the original word
                        s_nxt.ph   = opseq_pkg::PH_ORIG;
                        s_nxt.addr = s_r.oaddr;
                        s_nxt.pos  = opseq_pkg::CNT_RST;
                        s_nxt.rem  = 3'(opseq_pkg::PORT32_BYTES
                                        - {1'b0, s_r.oaddr[1:0]});
                     end else begin
                        s_nxt.st = opseq_pkg::ST_FINISH;
                     end
                  end
               end
            end
         end
         opseq_pkg::ST_FINISH: begin
            // costs a cycle per operand but keeps the extender off the ack path
            // writes leave the read value untouched
            if (!s_r.write) begin
               s_nxt.rdata = ext_value;
            end
            s_nxt.done = 1'b1;
            s_nxt.busy = 1'b0;
            s_nxt.st   = opseq_pkg::ST_IDLE;
         end
         default: begin
            s_nxt.st   = opseq_pkg::ST_IDLE;
            s_nxt.req  = 1'b0;
            s_nxt.busy = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '{st:     opseq_pkg::ST_IDLE,
                  ph:     opseq_pkg::PH_ONLY,
                  write:  1'b0,
                  sgn:    1'b0,
                  osize:  opseq_pkg::CNT_RST,
                  oaddr:  opseq_pkg::WORD_RST,
                  wdata:  opseq_pkg::WORD_RST,
                  addr:   opseq_pkg::WORD_RST,
                  rem:    opseq_pkg::CNT_RST,
                  pos:    opseq_pkg::CNT_RST,
                  port16: 1'b0,
                  acc:    opseq_pkg::WORD_RST,
                  busy:   1'b0,
                  done:   1'b0,
                  fault:  1'b0,
                  rdata:  opseq_pkg::WORD_RST,
                  req:    1'b0,
                  baddr:  opseq_pkg::WORD_RST,
                  bsize:  opseq_pkg::CNT_RST,
                  bwrite: 1'b0,
                  bwdata: opseq_pkg::WORD_RST};
      end else if (ce) begin
         // a low clock enable holds every field, outputs included
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register

   assign op_busy       = s_r.busy;
   assign op_done       = s_r.done;
   assign op_fault      = s_r.fault;
   assign op_rdata      = s_r.rdata;
   assign bus_req       = s_r.req;
   assign bus_addr      = s_r.baddr;
   assign transfer_size = s_r.bsize;
   assign bus_write     = s_r.bwrite;
   assign bus_wdata     = s_r.bwdata;

endmodule : operand_bus_access_sequencer

/* File: test/opseq_sva.sv */
// port assertions for the operand bus access sequencer
`timescale 1ns/100ps
module opseq_sva (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        ce,
   input wire logic        op_req,
   input wire logic        op_write,
   input wire logic [2:0]  op_size,
   input wire logic [31:0] op_addr,
   input wire logic        unaligned_enable,
   input wire logic        virtual_mode,
   input wire logic        op_busy,
   input wire logic        op_done,
   input wire logic        op_fault,
   input wire logic [31:0] op_rdata,
   input wire logic        bus_req,
   input wire logic [31:0] bus_addr,
   input wire logic [2:0]  transfer_size,
   input wire logic        bus_write,
   input wire logic [31:0] bus_wdata,
   input wire logic        bus_ack,
   input wire logic        bus_port16,
   input wire logic [31:0] bus_rdata
);
   default clocking cb @(posedge clk); endclocking
   // a frozen clock enable stretches every figure, so it aborts checks
   default disable iff (!nrst || !ce);
   logic take;
   logic misal;
   assign take  = op_req && !op_busy;
   assign misal = (op_size == opseq_pkg::XFER_HALF && op_addr[0])
                  || (op_size == opseq_pkg::XFER_WORD && op_addr[1:0] != 2'h0);
   ////////////////////////////////////////////////////////////////////////////////
   sequence ack_s;
      bus_req && bus_ack;
   endsequence
   sequence gap_s;
      !bus_req ##1 (bus_req || op_done);
   endsequence
   property first_p;
      logic [31:0] a;
      (take && (unaligned_enable || !misal), a = op_addr) |-> ##2 bus_req && bus_addr == a;
   endproperty
   ////////////////////////////////////////////////////////////////////////////////
   ack_gap_a: assert property (ack_s |=> gap_s)
      else $error("no release or follow-up after acknowledge");
   req_hold_a: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr)
      && $stable(transfer_size) && $stable(bus_wdata) && $stable(bus_write))
      else $error("bus request changed before acknowledge");
   first_addr_a: assert property (first_p)
      else $error("first transaction address is not the operand address");
   byte_repl_a: assert property (bus_req && bus_write
      && transfer_size == opseq_pkg::XFER_BYTE |-> bus_wdata[31:24] == bus_wdata[23:16]
      && bus_wdata[23:16] == bus_wdata[15:8] && bus_wdata[15:8] == bus_wdata[7:0])
      else $error("byte write not replicated");
   half_mirror_a: assert property (bus_req && bus_write && !bus_addr[0]
      && transfer_size == opseq_pkg::XFER_HALF |-> bus_wdata[31:16] == bus_wdata[15:0])
      else $error("aligned halfword write not mirrored");
   align_fault_a: assert property (take && !unaligned_enable && misal
      |=> op_done && op_fault && !bus_req ##1 !bus_req)
      else $error("misaligned access did not fault cleanly");
   aligned_ok_a: assert property (take && !unaligned_enable && !misal |=> !op_fault)
      else $error("aligned access faulted");
   probe_first_a: assert property (take && op_write && virtual_mode && unaligned_enable
      && op_size == opseq_pkg::XFER_WORD && op_addr[1:0] != 2'h0
      |-> ##2 bus_req && transfer_size == opseq_pkg::XFER_PROBE)
      else $error("crossing write did not start with a probe");
   no_probe_a: assert property (!virtual_mode && bus_req
      |-> transfer_size != opseq_pkg::XFER_PROBE)
      else $error("probe in physical mode");
   word_data_a: assert property (ack_s and (!bus_write && !bus_port16
      && transfer_size == opseq_pkg::XFER_WORD)
      |-> ##2 op_done && op_rdata == $past(bus_rdata, 2))
      else $error("aligned word load data wrong");
   narrow_more_a: assert property (ack_s and (bus_port16 && bus_addr[1:0] == 2'h0
      && transfer_size == opseq_pkg::XFER_WORD) |-> ##2 bus_req
      && transfer_size == opseq_pkg::XFER_HALF && bus_addr == $past(bus_addr, 2) + 32'h2)
      else $error("no second halfword after narrow acknowledge");
endmodule : opseq_sva

/* File: test/opseq_mem.sv */
// memory and port model on the far side of the sequencer bus
`timescale 1ns/100ps
module opseq_mem (
   input  wire logic        clk,
   input  wire logic        bus_req,
   input  wire logic [31:0] bus_addr,
   input  wire logic [2:0]  transfer_size,
   input  wire logic        bus_write,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        port16,
   input  wire logic        slow,
   output logic             bus_ack,
   output logic             bus_port16,
   output logic      [31:0] bus_rdata
);
   logic [7:0]  mem [256];
   logic [11:0] log [$];
   logic [7:0]  b;
   logic [7:0]  w;
   int          cnt;
   int          n;
   int          k;
   task automatic serve;
      b = bus_addr[7:0];
      w = {b[7:2], 2'h0};
      n = port16 ? 2 - b[0] : 4 - b[1:0];
      if (transfer_size < n) n = transfer_size;
      log.push_back({bus_write, transfer_size, b});
      for (int i = 0; i < n && bus_write; i++) begin
         k = b[1:0] + i;
         mem[w + k[7:0]] = bus_wdata[(port16 ? 3 - k % 2 : 3 - k) * 8 +: 8];
      end
      bus_rdata = {mem[w], mem[w + 8'h1], mem[w + 8'h2], mem[w + 8'h3]};
      if (port16) begin
         // a narrow port drives the inverted upper half onto the low half
         bus_rdata = b[1] ? {bus_rdata[15:0], ~bus_rdata[15:0]}
                          : {bus_rdata[31:16], ~bus_rdata[31:16]};
      end
      bus_port16 = port16;
      bus_ack = 1'h1;
   endtask : serve
   initial begin
      bus_ack = 1'h0;
      bus_port16 = 1'h0;
      bus_rdata = 32'h0;
      cnt = 0;
      for (int i = 0; i < 256; i++) mem[i] = i[7:0];
      forever begin
         @(posedge clk);
         #1;
         if (bus_req && !bus_ack && cnt < (slow ? 3 : 0)) begin
            cnt++;
         end else if (bus_req && !bus_ack) begin
            cnt = 0;
            serve();
         end else begin
            bus_ack = 1'h0;
            bus_port16 = 1'h0;
            bus_rdata = ~bus_rdata;
         end
      end
   end
endmodule : opseq_mem

/* File: test/operand_bus_access_sequencer_test.sv */
// self-checking bench for the operand bus access sequencer
`timescale 1ns/100ps
module operand_bus_access_sequencer_test;
   logic        clk = 1'h0;
   logic        nrst = 1'h0;
   logic        ce = 1'h1;
   logic        op_req = 1'h0;
   logic        op_write = 1'h0;
   logic        op_signed = 1'h0;
   logic [2:0]  op_size = 3'h0;
   logic [31:0] op_addr = 32'h0;
   logic [31:0] op_wdata = 32'h0;
   logic        unaligned_enable = 1'h1;
   logic        virtual_mode = 1'h0;
   logic        port16 = 1'h0;
   logic        slow = 1'h0;
   logic        op_busy, op_done, op_fault, bus_req, bus_write, bus_ack, bus_port16;
   logic [31:0] op_rdata, bus_addr, bus_wdata, bus_rdata, got;
   logic [2:0]  transfer_size;
   logic        got_fault;
   int          num_errors = 0;
   int          checks = 0;
   operand_bus_access_sequencer i_operand_bus_access_sequencer (
      .clk(clk), .nrst(nrst), .ce(ce), .op_req(op_req), .op_write(op_write),
      .op_signed(op_signed), .op_size(op_size), .op_addr(op_addr), .op_wdata(op_wdata),
      .unaligned_enable(unaligned_enable), .virtual_mode(virtual_mode), .op_busy(op_busy),
      .op_done(op_done), .op_fault(op_fault), .op_rdata(op_rdata), .bus_req(bus_req),
      .bus_addr(bus_addr), .transfer_size(transfer_size), .bus_write(bus_write),
      .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_port16(bus_port16), .bus_rdata(bus_rdata));
   opseq_mem i_opseq_mem (
      .clk(clk), .bus_req(bus_req), .bus_addr(bus_addr), .transfer_size(transfer_size),
      .bus_write(bus_write), .bus_wdata(bus_wdata), .port16(port16), .slow(slow),
      .bus_ack(bus_ack), .bus_port16(bus_port16), .bus_rdata(bus_rdata));
   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      if (num_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, e, input string m);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask : chk
   task automatic chk_seq(input logic [11:0] e[$]);
      chk(i_opseq_mem.log.size(), e.size(), "transaction count");
      foreach (e[i]) if (i < i_opseq_mem.log.size()) chk(i_opseq_mem.log[i], e[i], "txn");
   endtask : chk_seq
   function automatic logic [31:0] mw(input logic [7:0] a);
      return {i_opseq_mem.mem[a], i_opseq_mem.mem[a + 8'h1],
              i_opseq_mem.mem[a + 8'h2], i_opseq_mem.mem[a + 8'h3]};
   endfunction : mw
   task automatic do_op(input logic w, s, input logic [2:0] sz, input logic [7:0] a,
                        input logic [31:0] wd);
      int n;
      i_opseq_mem.log.delete();
      op_write = w;
      op_signed = s;
      op_size = sz;
      op_addr = {24'h0, a};
      op_wdata = wd;
      op_req = 1'h1;
      @(posedge clk);
      #1 op_req = 1'h0;
      n = 0;
      while (op_done !== 1'h1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      if (n == 100) chk(32'h0, 32'h1, "operand never finished");
      got = op_rdata;
      got_fault = op_fault;
      @(posedge clk);
      #1;
   endtask : do_op
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_ext;
      do_op(1'h0, 1'h1, 3'h1, 8'h80, 32'h0);
      chk(got, 32'hFFFFFF80, "signed byte");
      do_op(1'h0, 1'h1, 3'h2, 8'h90, 32'h0);
      chk(got, 32'hFFFF9091, "signed half");
      do_op(1'h0, 1'h0, 3'h1, 8'h85, 32'h0);
      chk(got, 32'h00000085, "unsigned byte");
      do_op(1'h0, 1'h0, 3'h2, 8'hA0, 32'h0);
      chk(got, 32'h0000A0A1, "unsigned half");
      do_op(1'h0, 1'h1, 3'h4, 8'h40, 32'h0);
      chk(got, 32'h40414243, "word");
   endtask : t_ext
   task automatic t_unal_rd;
      do_op(1'h0, 1'h0, 3'h4, 8'h11, 32'h0);
      chk(got, 32'h11121314, "word 01");
      chk_seq('{12'h311, 12'h114});
      do_op(1'h0, 1'h0, 3'h4, 8'h13, 32'h0);
      chk_seq('{12'h113, 12'h314});
      do_op(1'h0, 1'h0, 3'h4, 8'h12, 32'h0);
      chk(got, 32'h12131415, "word 10");
      chk_seq('{12'h212, 12'h214});
      do_op(1'h0, 1'h0, 3'h2, 8'h23, 32'h0);
      chk_seq('{12'h123, 12'h124});
   endtask : t_unal_rd
   task automatic t_fault;
      unaligned_enable = 1'h0;
      do_op(1'h0, 1'h0, 3'h4, 8'h31, 32'h0);
      chk(got_fault, 32'h1, "word fault");
      chk(i_opseq_mem.log.size(), 32'h0, "bus cycle on fault");
      do_op(1'h0, 1'h0, 3'h2, 8'h33, 32'h0);
      chk(got_fault, 32'h1, "half fault");
      do_op(1'h0, 1'h0, 3'h2, 8'h32, 32'h0);
      chk({got_fault, got[30:0]}, 32'h3233, "aligned half");
      do_op(1'h0, 1'h0, 3'h4, 8'h34, 32'h0);
      chk({got_fault, got[30:0]}, 32'h34353637, "aligned word");
      unaligned_enable = 1'h1;
   endtask : t_fault
   task automatic t_wr;
      virtual_mode = 1'h1;
      do_op(1'h1, 1'h0, 3'h4, 8'hC1, 32'hAABBCCDD);
      chk_seq('{12'h8C1, 12'h9C4, 12'hBC1});
      chk(mw(8'hC1), 32'hAABBCCDD, "crossing word stored");
      do_op(1'h1, 1'h0, 3'h2, 8'hD3, 32'hFFFF1234);
      chk_seq('{12'h8D3, 12'h9D4, 12'h9D3});
      chk(mw(8'hD2), 32'hD21234D5, "crossing half stored");
      do_op(1'h1, 1'h0, 3'h2, 8'hD9, 32'h5678);
      chk_seq('{12'hAD9});
      do_op(1'h1, 1'h0, 3'h1, 8'hE2, 32'hFFFFFF5A);
      chk(mw(8'hE0), 32'hE0E15AE3, "byte stored");
      virtual_mode = 1'h0;
      do_op(1'h1, 1'h0, 3'h4, 8'hCA, 32'h01020304);
      chk_seq('{12'hACA, 12'hACC});
      chk(mw(8'hCA), 32'h01020304, "physical word stored");
   endtask : t_wr
   task automatic t_narrow;
      port16 = 1'h1;
      slow = 1'h1;
      do_op(1'h0, 1'h0, 3'h4, 8'h40, 32'h0);
      chk(got, 32'h40414243, "narrow word");
      chk_seq('{12'h440, 12'h242});
      do_op(1'h0, 1'h0, 3'h4, 8'h11, 32'h0);
      chk(got, 32'h11121314, "narrow word 01");
      chk_seq('{12'h311, 12'h212, 12'h114});
      do_op(1'h0, 1'h0, 3'h1, 8'h07, 32'h0);
      chk(got, 32'h7, "narrow byte");
      do_op(1'h1, 1'h0, 3'h4, 8'hF0, 32'hCAFEBABE);
      chk_seq('{12'hCF0, 12'hAF2});
      chk(mw(8'hF0), 32'hCAFEBABE, "narrow word stored");
      port16 = 1'h0;
      slow = 1'h0;
   endtask : t_narrow
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk);
      #1 nrst = 1'h1;
      chk({op_busy, op_done, op_fault, bus_req}, 32'h0, "idle after reset");
      t_ext();
      t_unal_rd();
      t_fault();
      t_wr();
      t_narrow();
      test_done();
   end
   initial begin
      #400000;
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done();
   end
endmodule : operand_bus_access_sequencer_test
bind operand_bus_access_sequencer opseq_sva i_opseq_sva (
   .clk(clk), .nrst(nrst), .ce(ce), .op_req(op_req), .op_write(op_write), .op_size(op_size),
   .op_addr(op_addr), .unaligned_enable(unaligned_enable), .virtual_mode(virtual_mode),
   .op_busy(op_busy), .op_done(op_done), .op_fault(op_fault), .op_rdata(op_rdata),
   .bus_req(bus_req), .bus_addr(bus_addr), .transfer_size(transfer_size),
   .bus_write(bus_write), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
   .bus_port16(bus_port16), .bus_rdata(bus_rdata));
